// ===== tpw_pkg.sv
// constants of the 16-bit PWM timer: register map, fields, modes, tops
// assumes a 32-bit AHB-Lite register bus and one word per register
package tpw_pkg;

   // register byte offsets
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  CMPA_OFS     = 8'h04;
   localparam logic [7:0]  CMPB_OFS     = 8'h08;
   localparam logic [7:0]  CAPT_OFS     = 8'h0C;
   localparam logic [7:0]  COUNT_OFS    = 8'h10;
   localparam logic [7:0]  FLAGS_OFS    = 8'h14;

   // control register fields
   localparam int          WGM_LSB      = 0;
   localparam int          COMA_LSB     = 4;
   localparam int          COMB_LSB     = 6;
   localparam int          CS_LSB       = 8;
   localparam int          DIRA_BIT     = 11;
   localparam int          DIRB_BIT     = 12;
   localparam int          CTRL_W       = 13;
   localparam logic [12:0] CTRL_RST     = 13'h0000;

   // flag register bits
   localparam int          FLG_OVF      = 0;
   localparam int          FLG_CAP      = 1;
   localparam int          FLG_CMPA     = 2;
   localparam int          FLG_CMPB     = 3;
   localparam int          FLG_W        = 4;
   localparam logic [3:0]  FLAGS_RST    = 4'h0;

   // waveform modes
   localparam logic [3:0]  WGM_PC8      = 4'h1;
   localparam logic [3:0]  WGM_PC9      = 4'h2;
   localparam logic [3:0]  WGM_PC10     = 4'h3;
   localparam logic [3:0]  WGM_FP8      = 4'h5;
   localparam logic [3:0]  WGM_FP9      = 4'h6;
   localparam logic [3:0]  WGM_FP10     = 4'h7;
   localparam logic [3:0]  WGM_PC_CAP   = 4'hA;
   localparam logic [3:0]  WGM_PC_CMPA  = 4'hB;
   localparam logic [3:0]  WGM_FP_CAP   = 4'hE;
   localparam logic [3:0]  WGM_FP_CMPA  = 4'hF;

   // compare output modes
   localparam logic [1:0]  COM_OFF      = 2'h0;
   localparam logic [1:0]  COM_TOGGLE   = 2'h1;
   localparam logic [1:0]  COM_TWO      = 2'h2;
   localparam logic [1:0]  COM_THREE    = 2'h3;

   // counter values and reset values
   localparam logic [15:0] TOP_8BIT     = 16'h00FF;
   localparam logic [15:0] TOP_9BIT     = 16'h01FF;
   localparam logic [15:0] TOP_10BIT    = 16'h03FF;
   localparam logic [15:0] BOTTOM       = 16'h0000;
   localparam logic [15:0] FULL_MASK    = 16'hFFFF;
   localparam logic [15:0] WORD_RST     = 16'h0000;

   // prescaler selections and divider low-bit masks
   localparam logic [2:0]  CS_STOP      = 3'h0;
   localparam logic [2:0]  CS_DIV1      = 3'h1;
   localparam logic [2:0]  CS_DIV8      = 3'h2;
   localparam logic [2:0]  CS_DIV64     = 3'h3;
   localparam logic [2:0]  CS_DIV256    = 3'h4;
   localparam logic [2:0]  CS_DIV1024   = 3'h5;
   localparam logic [9:0]  MSK_DIV8     = 10'h007;
   localparam logic [9:0]  MSK_DIV64    = 10'h03F;
   localparam logic [9:0]  MSK_DIV256   = 10'h0FF;
   localparam logic [9:0]  MSK_DIV1024  = 10'h3FF;

   // ahb encodings
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;

endpackage : tpw_pkg

// ===== tpw_presc_if.sv
// carrier between the timer core and its prescaler
// assumes both ends run on the same bus clock
`timescale 1ns/1ps
`default_nettype none
interface tpw_presc_if;
   logic [2:0] sel;
   logic       tick;
   modport ctl (output sel, input tick);
   modport pre (input sel, output tick);
endinterface : tpw_presc_if
`default_nettype wire

// ===== tpw_prescaler.sv
// prescaler: one-cycle timer tick every 1, 8, 64, 256 or 1024 clocks
// assumes the selection comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module tpw_prescaler
   import tpw_pkg::*;
#(
   parameter int DIV_W = 10
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   tpw_presc_if.pre  presc
);
   // the divider taps are fixed at 10 bits; refuse any other width
   if (DIV_W != 10) begin : g_div_w_chk
      $error("prescaler divider must be 10 bits");
   end

   logic [9:0] div_reg;
   logic [9:0] div_next;
   logic       tick_c;

   always_comb begin
      div_next = div_reg + 10'h001;
      tick_c   = 1'b0;
      case (presc.sel)
         CS_DIV1:    tick_c = 1'b1;
         CS_DIV8:    tick_c = (div_reg & MSK_DIV8) == MSK_DIV8;
         CS_DIV64:   tick_c = (div_reg & MSK_DIV64) == MSK_DIV64;
         CS_DIV256:  tick_c = (div_reg & MSK_DIV256) == MSK_DIV256;
         CS_DIV1024: tick_c = div_reg == MSK_DIV1024;
         default:    tick_c = 1'b0;
      endcase
      // a stopped timer also stops the divider so it restarts in phase
      if (presc.sel == CS_STOP) begin
         div_next = 10'h000;
      end
   end

   assign presc.tick = tick_c;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= 10'h000;
      end else begin
         div_reg <= div_next;
      end
   end

endmodule : tpw_prescaler
`default_nettype wire

// ===== tpw_timer.sv
// 16-bit timer in fast and phase correct pwm, two compare outputs
// assumes an ahb-lite master on hclk; pin outputs drive an external pad
`timescale 1ns/1ps
`default_nettype none
module tpw_timer
   import tpw_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             out_a,
   output logic             out_a_oe,
   output logic             out_b,
   output logic             out_b_oe
);

   tpw_presc_if presc ();

   tpw_prescaler #(.DIV_W(10)) u_presc (
      .hclk    (hclk),
      .hresetn (hresetn),
      .presc   (presc)
   );

   // state
   logic [CTRL_W-1:0] ctrl_reg,   ctrl_next;
   logic [15:0]       buf_a_reg,  buf_a_next;
   logic [15:0]       buf_b_reg,  buf_b_next;
   logic [15:0]       act_a_reg,  act_a_next;
   logic [15:0]       act_b_reg,  act_b_next;
   logic [15:0]       capt_reg,   capt_next;
   logic [15:0]       cnt_reg,    cnt_next;
   logic              up_reg,     up_next;
   logic [FLG_W-1:0]  flags_reg,  flags_next;
   logic              st_a_reg,   st_a_next;
   logic              st_b_reg,   st_b_next;
   logic              wr_reg,     wr_next;
   logic [7:0]        waddr_reg,  waddr_next;
   logic [31:0]       rdata_reg,  rdata_next;
   logic              oea_reg,    oea_next;
   logic              oeb_reg,    oeb_next;
   logic              pa_reg,     pa_next;
   logic              pb_reg,     pb_next;

   // decoded controls
   logic [3:0]  wgm;
   logic [1:0]  com_a;
   logic [1:0]  com_b;
   logic        fast;
   logic        pc;
   logic        tick;
   logic [15:0] top;
   logic        at_top;
   logic        up_phase;
   logic        match_a;
   logic        match_b;
   logic        addr_ok;

   function automatic logic is_fast(input logic [3:0] m);
      return (m == WGM_FP8) || (m == WGM_FP9) || (m == WGM_FP10) ||
             (m == WGM_FP_CAP) || (m == WGM_FP_CMPA);
   endfunction : is_fast

   function automatic logic is_pc(input logic [3:0] m);
      return (m == WGM_PC8) || (m == WGM_PC9) || (m == WGM_PC10) ||
             (m == WGM_PC_CAP) || (m == WGM_PC_CMPA);
   endfunction : is_pc

   // bits a compare register keeps under the fixed resolutions
   function automatic logic [15:0] res_mask(input logic [3:0] m);
      case (m)
         WGM_PC8,  WGM_FP8:  return TOP_8BIT;
         WGM_PC9,  WGM_FP9:  return TOP_9BIT;
         WGM_PC10, WGM_FP10: return TOP_10BIT;
         default:            return FULL_MASK;
      endcase
   endfunction : res_mask

   function automatic logic top_is_cap(input logic [3:0] m);
      return (m == WGM_PC_CAP) || (m == WGM_FP_CAP);
   endfunction : top_is_cap

   function automatic logic top_is_cmpa(input logic [3:0] m);
      return (m == WGM_PC_CMPA) || (m == WGM_FP_CMPA);
   endfunction : top_is_cmpa

   // next output state of one compare unit
   function automatic logic wave(input logic       st,
                                 input logic [1:0] com,
                                 input logic       fst,
                                 input logic       topev,
                                 input logic       match,
                                 input logic       upm,
                                 input logic       tog_ok);
      logic r;
      r = st;
      if (com == COM_TOGGLE) begin
         if (tog_ok && match) r = ~st;
      end else if (com != COM_OFF) begin
         if (fst) begin
            // the wrap to bottom wins over a match at top: constant level
            if (topev) r = (com == COM_THREE);
            else if (match) r = (com == COM_TWO);
         end else if (match) begin
            r = upm ? (com == COM_THREE) : (com == COM_TWO);
         end
      end
      return r;
   endfunction : wave

   assign wgm   = ctrl_reg[WGM_LSB +: 4];
   assign com_a = ctrl_reg[COMA_LSB +: 2];
   assign com_b = ctrl_reg[COMB_LSB +: 2];
   assign fast  = is_fast(wgm);
   assign pc    = is_pc(wgm);
   assign presc.sel = ctrl_reg[CS_LSB +: 3];
   assign tick  = presc.tick;
   // capture top read straight from its register, no buffer
   assign top   = top_is_cap(wgm)  ? capt_reg :
                  top_is_cmpa(wgm) ? act_a_reg : res_mask(wgm);
   assign at_top   = cnt_reg == top;
   // a match at top counts as falling, at bottom as rising: extremes hold
   assign up_phase = !at_top && (up_reg || cnt_reg == BOTTOM);
   assign match_a  = cnt_reg == act_a_reg;
   assign match_b  = cnt_reg == act_b_reg;
   assign addr_ok  = hsel && hready && htrans[1] && hsize == HSIZE_WORD;

   // bus side
   always_comb begin
      wr_next    = addr_ok && hwrite;
      waddr_next = haddr[7:0];
      rdata_next = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            CTRL_OFS:  rdata_next = {19'h00000, ctrl_reg};
            CMPA_OFS:  rdata_next = {16'h0000, buf_a_reg};
            CMPB_OFS:  rdata_next = {16'h0000, buf_b_reg};
            CAPT_OFS:  rdata_next = {16'h0000, capt_reg};
            COUNT_OFS: rdata_next = {16'h0000, cnt_reg};
            FLAGS_OFS: rdata_next = {28'h0000000, flags_reg};
            default:   rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // timer core
   always_comb begin
      ctrl_next  = ctrl_reg;
      buf_a_next = buf_a_reg;
      buf_b_next = buf_b_reg;
      act_a_next = act_a_reg;
      act_b_next = act_b_reg;
      capt_next  = capt_reg;
      cnt_next   = cnt_reg;
      up_next    = up_reg;
      flags_next = flags_reg;
      st_a_next  = st_a_reg;
      st_b_next  = st_b_reg;
      if (wr_reg) begin
         case (waddr_reg)
            CTRL_OFS:  ctrl_next  = hwdata[CTRL_W-1:0];
            CMPA_OFS:  buf_a_next = hwdata[15:0] & res_mask(wgm);
            CMPB_OFS:  buf_b_next = hwdata[15:0] & res_mask(wgm);
            CAPT_OFS:  capt_next  = hwdata[15:0];
            COUNT_OFS: cnt_next   = hwdata[15:0];
            FLAGS_OFS: flags_next = flags_reg & ~hwdata[FLG_W-1:0];
            default:   ;
         endcase
      end
      if (!fast && !pc) begin
         // outside pwm the compare values are not double buffered
         act_a_next = buf_a_reg;
         act_b_next = buf_b_reg;
         up_next    = 1'b1;
      end else if (tick) begin
         if (match_a) flags_next[FLG_CMPA] = 1'b1;
         if (match_b) flags_next[FLG_CMPB] = 1'b1;
         st_a_next = wave(st_a_reg, com_a, fast, at_top, match_a, up_phase,
                          top_is_cmpa(wgm));
         st_b_next = wave(st_b_reg, com_b, fast, at_top, match_b, up_phase,
                          1'b0);
         if (at_top && (fast || up_reg)) begin
            act_a_next = buf_a_reg;
            act_b_next = buf_b_reg;
            if (top_is_cap(wgm))  flags_next[FLG_CAP]  = 1'b1;
            if (top_is_cmpa(wgm)) flags_next[FLG_CMPA] = 1'b1;
         end
         if (fast) begin
            up_next = 1'b1;
            if (at_top) begin
               cnt_next = BOTTOM;
               flags_next[FLG_OVF] = 1'b1;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end else if (up_reg) begin
            if (at_top) begin
               up_next  = 1'b0;
               cnt_next = cnt_reg - 16'h0001;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end else if (cnt_reg == BOTTOM) begin
            up_next  = 1'b1;
            cnt_next = cnt_reg + 16'h0001;
            flags_next[FLG_OVF] = 1'b1;
         end else begin
            cnt_next = cnt_reg - 16'h0001;
         end
      end
   end

   // pin drivers
   always_comb begin
      oea_next = ctrl_next[DIRA_BIT] && ctrl_next[COMA_LSB +: 2] != COM_OFF;
      oeb_next = ctrl_next[DIRB_BIT] && ctrl_next[COMB_LSB +: 2] != COM_OFF;
      pa_next  = st_a_next;
      pb_next  = st_b_next;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg  <= CTRL_RST;
         buf_a_reg <= WORD_RST;
         buf_b_reg <= WORD_RST;
         act_a_reg <= WORD_RST;
         act_b_reg <= WORD_RST;
         capt_reg  <= WORD_RST;
         cnt_reg   <= WORD_RST;
         up_reg    <= 1'b1;
         flags_reg <= FLAGS_RST;
         st_a_reg  <= 1'b0;
         st_b_reg  <= 1'b0;
         wr_reg    <= 1'b0;
         waddr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
         oea_reg   <= 1'b0;
         oeb_reg   <= 1'b0;
         pa_reg    <= 1'b0;
         pb_reg    <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         buf_a_reg <= buf_a_next;
         buf_b_reg <= buf_b_next;
         act_a_reg <= act_a_next;
         act_b_reg <= act_b_next;
         capt_reg  <= capt_next;
         cnt_reg   <= cnt_next;
         up_reg    <= up_next;
         flags_reg <= flags_next;
         st_a_reg  <= st_a_next;
         st_b_reg  <= st_b_next;
         wr_reg    <= wr_next;
         waddr_reg <= waddr_next;
         rdata_reg <= rdata_next;
         oea_reg   <= oea_next;
         oeb_reg   <= oeb_next;
         pa_reg    <= pa_next;
         pb_reg    <= pb_next;
      end
   end

   // zero wait states: every transfer completes with OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata   = rdata_reg;
   assign out_a    = pa_reg;
   assign out_a_oe = oea_reg;
   assign out_b    = pb_reg;
   assign out_b_oe = oeb_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_fast_wrap: assert property (
      tick && fast && at_top && !wr_reg |=> cnt_reg == BOTTOM
   ) else $error("fast mode did not clear after top");

   chk_fast_step: assert property (
      tick && fast && !at_top && !wr_reg |=> cnt_reg == $past(cnt_reg) + 16'h0001
   ) else $error("fast mode did not count up");

   chk_top_flags: assert property (
      tick && fast && at_top |=> flags_reg[FLG_OVF] &&
      (!top_is_cmpa($past(wgm)) || flags_reg[FLG_CMPA])
   ) else $error("top flags missing in fast mode");

   chk_pc_turn: assert property (
      tick && pc && up_reg && at_top && !wr_reg |=>
      !up_reg && cnt_reg == $past(cnt_reg) - 16'h0001
   ) else $error("phase correct did not turn at top");

   chk_pc_ovf: assert property (
      tick && pc && !up_reg && cnt_reg == BOTTOM |=> flags_reg[FLG_OVF] && up_reg
   ) else $error("phase correct overflow not set at bottom");

   chk_cmp_flag: assert property (
      tick && (fast || pc) && match_b |=> flags_reg[FLG_CMPB]
   ) else $error("compare flag missing on match");

   chk_buf_load: assert property (
      tick && fast && at_top |=> act_a_reg == $past(buf_a_reg)
   ) else $error("compare buffer not loaded at top");

   chk_pin_gate: assert property (
      !ctrl_reg[DIRA_BIT] && !(wr_reg && waddr_reg == CTRL_OFS) |=> !out_a_oe
   ) else $error("pin driven while direction is input");

   chk_fast_set: assert property (
      tick && fast && at_top && com_a == COM_THREE |=> out_a
   ) else $error("non-inverting output not set at bottom");

   chk_mask_fix: assert property (
      wr_reg && waddr_reg == CMPB_OFS |=> (buf_b_reg & ~res_mask($past(wgm))) == 16'h0000
   ) else $error("compare bits above resolution kept");

endmodule : tpw_timer
`default_nettype wire

// ===== tpw_load_model.sv
// external load on the two pwm pads: counts high samples per window
// assumes a weak pull-down on each pad while the timer releases it
`timescale 1ns/1ps
`default_nettype none
module tpw_load_model (
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic        drv_a,
   input  wire logic        oe_a,
   input  wire logic        drv_b,
   input  wire logic        oe_b,
   output logic [15:0]      hi_a,
   output logic [15:0]      hi_b
);
   logic pad_a;
   logic pad_b;
   // released pad falls to the pull-down, never keeps the last level
   assign pad_a = oe_a ? drv_a : 1'b0;
   assign pad_b = oe_b ? drv_b : 1'b0;
   always_ff @(posedge clk) begin
      hi_a <= clr ? 16'h0000 : hi_a + {15'h0000, pad_a};
      hi_b <= clr ? 16'h0000 : hi_b + {15'h0000, pad_b};
   end
endmodule : tpw_load_model
`default_nettype wire

// ===== tpw_timer_tb_top.sv
// self-checking bench of the pwm timer: duty counts on both pads
// assumes zero-wait slave; prescaler at divide-by-one unless stated
`timescale 1ns/1ps
`default_nettype none
module tpw_timer_tb_top;
   import tpw_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout, hresp, out_a, out_a_oe, out_b, out_b_oe;
   logic        clr = 1'b1;
   logic [31:0] hrdata, q;
   logic [15:0] hi_a, hi_b;
   int          num_errors = 0;
   int          cmp_count = 0;

   always #12.5 hclk = ~hclk;

   tpw_timer tpw_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .out_a(out_a), .out_a_oe(out_a_oe),
      .out_b(out_b), .out_b_oe(out_b_oe));
   tpw_load_model tpw_load_model_inst (.clk(hclk), .clr(clr),
      .drv_a(out_a), .oe_a(out_a_oe), .drv_b(out_b), .oe_b(out_b_oe),
      .hi_a(hi_a), .hi_b(hi_b));

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   // one single word transfer; read data is taken at the data phase edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : xfer

   function automatic logic [31:0] mk(input logic [3:0] w,
      input logic [1:0] ca, cb, input logic [2:0] cs, input logic da, db);
      return {19'h00000, db, da, cs, cb, ca, w};
   endfunction : mk

   // stop, load tops and compares, restart, settle, then count pad highs
   task automatic run(input logic [31:0] ctl, input logic [15:0] top, ca,
                      cb, input int n, input logic [15:0] ea, eb);
      xfer(1'b1, CTRL_OFS, 32'h0, q);
      xfer(1'b1, CAPT_OFS, {16'h0, top}, q);
      xfer(1'b1, CMPA_OFS, {16'h0, ca}, q);
      xfer(1'b1, CMPB_OFS, {16'h0, cb}, q);
      xfer(1'b1, COUNT_OFS, 32'h0, q);
      xfer(1'b1, CTRL_OFS, ctl, q);
      repeat (n / 2) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (n) @(posedge hclk);
      #1;
      chk("pad a highs", {16'h0, ea}, {16'h0, hi_a});
      chk("pad b highs", {16'h0, eb}, {16'h0, hi_b});
   endtask : run

   task automatic s_regs;
      chk("reset out a", 32'h0, {31'h0, out_a});
      chk("reset oe a", 32'h0, {31'h0, out_a_oe});
      xfer(1'b1, 8'h20, 32'h5A5A_5A5A, q);
      xfer(1'b0, 8'h20, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      xfer(1'b1, CTRL_OFS, mk(WGM_FP9, 2'h0, 2'h0, CS_STOP, 1'b0, 1'b0), q);
      xfer(1'b1, CMPA_OFS, 32'h0000_FFFF, q);
      xfer(1'b0, CMPA_OFS, 32'h0, q);
      chk("masked compare a", 32'h0000_01FF, q);
      xfer(1'b1, CMPB_OFS, 32'h0000_FFFF, q);
      xfer(1'b0, CMPB_OFS, 32'h0, q);
      chk("masked compare b", 32'h0000_01FF, q);
   endtask : s_regs

   task automatic s_flags;
      run(mk(WGM_FP_CAP, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 40, 16'h0, 16'h10);
      xfer(1'b1, FLAGS_OFS, 32'hF, q);
      repeat (30) @(posedge hclk);
      xfer(1'b0, FLAGS_OFS, 32'h0, q);
      chk("fast flags", 32'hF, q);
      run(mk(WGM_PC_CAP, 2'h0, 2'h2, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 36, 16'h0, 16'h0C);
      xfer(1'b1, CTRL_OFS, 32'h0, q);
      xfer(1'b1, FLAGS_OFS, 32'hF, q);
      xfer(1'b0, FLAGS_OFS, 32'h0, q);
      chk("flags after clear", 32'h0, q);
   endtask : s_flags

   task automatic end_of_test;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      // all scenarios together take well under 10000 clocks
      repeat (30000) @(posedge hclk);
      num_errors++;
      end_of_test();
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      s_regs();
      // software keeps every compare at or below top in all runs
      run(mk(WGM_FP_CAP, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 100, 16'h0, 16'd40);
      run(mk(WGM_FP_CAP, 2'h0, 2'h2, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 100, 16'h0, 16'd60);
      run(mk(WGM_FP_CAP, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h0, 100, 16'h0, 16'd10);
      run(mk(WGM_FP_CAP, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h9, 100, 16'h0, 16'd100);
      run(mk(WGM_FP_CAP, 2'h0, 2'h3, CS_DIV8, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 800, 16'h0, 16'd320);
      run(mk(WGM_FP8, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 512, 16'h0, 16'd8);
      run(mk(WGM_FP10, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 1024, 16'h0, 16'd4);
      run(mk(WGM_PC8, 2'h0, 2'h2, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 510, 16'h0, 16'd6);
      run(mk(WGM_PC_CAP, 2'h0, 2'h2, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 180, 16'h0, 16'd60);
      run(mk(WGM_PC_CAP, 2'h0, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h3, 180, 16'h0, 16'd120);
      run(mk(WGM_PC_CAP, 2'h0, 2'h2, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h0, 180, 16'h0, 16'd0);
      run(mk(WGM_PC_CAP, 2'h0, 2'h2, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h0, 16'h9, 180, 16'h0, 16'd180);
      run(mk(WGM_FP_CMPA, 2'h1, 2'h0, CS_DIV1, 1'b1, 1'b1), 16'h9, 16'h4, 16'h0, 100, 16'd50, 16'h0);
      run(mk(WGM_PC_CMPA, 2'h1, 2'h0, CS_DIV1, 1'b1, 1'b1), 16'h9, 16'h4, 16'h0, 160, 16'd80, 16'h0);
      run(mk(WGM_FP_CAP, 2'h3, 2'h3, CS_DIV1, 1'b0, 1'b1), 16'h9, 16'h3, 16'h3, 100, 16'h0, 16'd40);
      chk("released oe a", 32'h0, {31'h0, out_a_oe});
      s_flags();
      end_of_test();
   end
endmodule : tpw_timer_tb_top
`default_nettype wire
